// [sram_port_pkg.sv]
package sram_port_pkg;

  localparam int ADDR_W     = 19;
  localparam int LANES      = 4;
  localparam int BYTE_W     = 8;
  localparam int LANE_W     = 9;
  localparam int DATA_W     = LANES * BYTE_W;
  localparam int WORD_W     = LANES * LANE_W;
  localparam int WORDS      = 1 << ADDR_W;
  localparam int BURST_W    = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int ENTRY_W    = ADDR_W + LANES + WORD_W;

  localparam logic [ADDR_W-1:0]  ADDR_RESET     = 19'h00000;
  localparam logic [BURST_W-1:0] BURST_RESET    = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP     = 2'h1;
  localparam logic [LANES-1:0]   LANE_SEL_RESET = 4'hF;

  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_READ,
    PHASE_WRITE
  } phase_type;

endpackage

// [write_fifo.sv]
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // Fill side
  input  wire logic             IN_VALID,
  output wire logic             IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  // Drain side
  output wire logic             OUT_VALID,
  input  wire logic             OUT_READY,
  output wire logic [WIDTH-1:0] OUT_DATA
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;

  wire push = IN_VALID & IN_READY;
  wire pop  = OUT_VALID & OUT_READY;

  assign IN_READY  = count != (PW+1)'(DEPTH);
  assign OUT_VALID = count != '0;
  assign OUT_DATA  = slots[rd_ptr];

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= PW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= PW'(rd_ptr + 1'b1);
      count <= (PW+1)'(count + push - pop);
    end
  end

  always_ff @(posedge CLK) begin
    if (push) slots[wr_ptr] <= IN_DATA;
  end

endmodule

// [sram_port.sv]
`timescale 1ns/1ps
module sram_port (
  // Clock and reset
  input  wire logic                              CLK,
  input  wire logic                              RST,
  // Synchronous command inputs
  input  wire logic [sram_port_pkg::ADDR_W-1:0]  ADDRESS,
  input  wire logic                              CLOCK_GATE_N,
  input  wire logic                              CHIP_SELECT_FIRST_N,
  input  wire logic                              CHIP_SELECT_SECOND,
  input  wire logic                              CHIP_SELECT_THIRD_N,
  input  wire logic                              WRITE_N,
  input  wire logic [sram_port_pkg::LANES-1:0]   BYTE_LANE_WRITE_SEL_N,
  input  wire logic                              ADVANCE_OR_LOAD,
  // Asynchronous controls
  input  wire logic                              OUTPUT_DRIVE_N,
  input  wire logic                              SLEEP_REQUEST,
  input  wire logic                              BURST_INTERLEAVED,
  // Data pins, split into in, out and enable
  input  wire logic [sram_port_pkg::DATA_W-1:0]  DATA_IN,
  output wire logic [sram_port_pkg::DATA_W-1:0]  DATA_OUT,
  input  wire logic [sram_port_pkg::LANES-1:0]   PARITY_LANE_IN,
  output wire logic [sram_port_pkg::LANES-1:0]   PARITY_LANE_OUT,
  output wire logic                              DATA_OE_N,
  // Status
  output wire logic                              LOW_POWER
);

  localparam int AW = sram_port_pkg::ADDR_W;
  localparam int LN = sram_port_pkg::LANES;
  localparam int LW = sram_port_pkg::LANE_W;
  localparam int BW = sram_port_pkg::BYTE_W;
  localparam int WW = sram_port_pkg::WORD_W;
  localparam int EW = sram_port_pkg::ENTRY_W;

  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] count,
                                           input logic       interleave);
    return interleave ? (start ^ count) : 2'(start + count);
  endfunction

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Pin synchronisers for the sleep and burst-mode level inputs
  logic sleep_meta;
  logic sleep_sync;
  logic mode_meta;
  logic mode_sync;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      mode_meta  <= 1'b0;
      mode_sync  <= 1'b0;
    end else begin
      sleep_meta <= SLEEP_REQUEST;
      sleep_sync <= sleep_meta;
      mode_meta  <= BURST_INTERLEAVED;
      mode_sync  <= mode_meta;
    end
  end

  // Registered command state
  sram_port_pkg::phase_type phase;
  sram_port_pkg::phase_type next_phase;
  logic [AW-1:0]            cur_addr;
  logic [AW-1:0]            next_addr;
  logic [LN-1:0]            lane_sel_n;
  logic [1:0]               burst_start;
  logic [1:0]               next_start;
  logic [1:0]               burst_count;
  logic [1:0]               next_count;

  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [EW-1:0] fifo_out_data;

  wire selected      = !CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND
                       & !CHIP_SELECT_THIRD_N;
  wire load_cycle    = !ADVANCE_OR_LOAD;
  wire write_pending = phase == sram_port_pkg::PHASE_WRITE;
  wire read_phase    = phase == sram_port_pkg::PHASE_READ;
  wire stall         = CLOCK_GATE_N | (write_pending & !fifo_in_ready);
  wire [1:0] advanced_count = 2'(burst_count + sram_port_pkg::BURST_STEP);

  always_comb begin
    next_phase = phase;
    next_addr  = cur_addr;
    next_start = burst_start;
    next_count = burst_count;
    if (sleep_sync) begin
      next_phase = sram_port_pkg::PHASE_IDLE;
    end else if (load_cycle) begin
      if (!selected) begin
        next_phase = sram_port_pkg::PHASE_IDLE;
      end else begin
        next_phase = WRITE_N ? sram_port_pkg::PHASE_READ
                             : sram_port_pkg::PHASE_WRITE;
        next_addr  = ADDRESS;
        next_start = ADDRESS[1:0];
        next_count = sram_port_pkg::BURST_RESET;
      end
    end else if (phase != sram_port_pkg::PHASE_IDLE) begin
      next_count = advanced_count;
      next_addr  = {cur_addr[AW-1:2],
                    burst_low(burst_start, advanced_count, mode_sync)};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase       <= sram_port_pkg::PHASE_IDLE;
      cur_addr    <= sram_port_pkg::ADDR_RESET;
      lane_sel_n  <= sram_port_pkg::LANE_SEL_RESET;
      burst_start <= sram_port_pkg::BURST_RESET;
      burst_count <= sram_port_pkg::BURST_RESET;
    end else if (!stall) begin
      phase       <= next_phase;
      cur_addr    <= next_addr;
      lane_sel_n  <= BYTE_LANE_WRITE_SEL_N;
      burst_start <= next_start;
      burst_count <= next_count;
    end
  end

  property p_stall_holds;
    stall |=> $stable(phase) && $stable(cur_addr) && $stable(burst_count);
  endproperty
  a_stall_holds: assert property (p_stall_holds)
    else $error("State moved during a stalled cycle");

  property p_load_address;
    !stall && !sleep_sync && load_cycle && selected
      |=> cur_addr == $past(ADDRESS)
          && lane_sel_n == $past(BYTE_LANE_WRITE_SEL_N);
  endproperty
  a_load_address: assert property (p_load_address)
    else $error("Load did not register the address");

  property p_write_follows;
    !stall && !sleep_sync && load_cycle && selected && !WRITE_N
      |=> phase == sram_port_pkg::PHASE_WRITE;
  endproperty
  a_write_follows: assert property (p_write_follows)
    else $error("Write command did not start a write phase");

  property p_deselect_idle;
    !stall && load_cycle && !selected |=> phase == sram_port_pkg::PHASE_IDLE;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle)
    else $error("Deselect did not leave the port idle");

  property p_burst_step;
    !stall && !sleep_sync && !load_cycle
      && phase != sram_port_pkg::PHASE_IDLE
      |=> burst_count == 2'($past(burst_count) + 2'h1)
          && cur_addr[AW-1:2] == $past(cur_addr[AW-1:2]);
  endproperty
  a_burst_step: assert property (p_burst_step)
    else $error("Burst advance did not step the counter");

  // Write capture one cycle after the address, then a self-timed commit
  logic [WW-1:0] in_word;
  logic [WW-1:0] rd_word;
  logic [WW-1:0] mem [sram_port_pkg::WORDS];

  wire           fifo_in_valid = write_pending & !CLOCK_GATE_N;
  wire           fifo_out_ready = !sleep_sync;
  wire           commit = fifo_out_valid & fifo_out_ready;
  wire [AW-1:0]  entry_addr  = fifo_out_data[EW-1 -: AW];
  wire [LN-1:0]  entry_sel_n = fifo_out_data[WW +: LN];
  wire [WW-1:0]  entry_word  = fifo_out_data[WW-1:0];

  for (genvar k = 0; k < LN; k++) begin : g_lane
    assign in_word[k*LW +: LW]    = {PARITY_LANE_IN[k], DATA_IN[k*BW +: BW]};
    assign DATA_OUT[k*BW +: BW]   = rd_word[k*LW +: BW];
    assign PARITY_LANE_OUT[k]     = rd_word[k*LW + BW];
  end

  write_fifo #(
    .WIDTH (EW),
    .DEPTH (sram_port_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .IN_VALID  (fifo_in_valid),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   ({cur_addr, lane_sel_n, in_word}),
    .OUT_VALID (fifo_out_valid),
    .OUT_READY (fifo_out_ready),
    .OUT_DATA  (fifo_out_data)
  );

  always_ff @(posedge CLK) begin
    for (int k = 0; k < LN; k++) begin
      if (commit && !entry_sel_n[k]) begin
        mem[entry_addr][k*LW +: LW] <= entry_word[k*LW +: LW];
      end
    end
  end

  property p_write_queued;
    fifo_in_valid && fifo_in_ready |=> fifo_out_valid;
  endproperty
  a_write_queued: assert property (p_write_queued)
    else $error("Captured write was not queued for commit");

  // Lane 1 masked on a commit keeps its old contents
  property p_lane_masked;
    commit && entry_sel_n[1]
      |=> mem[$past(entry_addr)][LW +: LW]
          == $past(mem[entry_addr][LW +: LW]);
  endproperty
  a_lane_masked: assert property (p_lane_masked)
    else $error("Masked lane changed on a commit");

  // Flow-through read and output drive control
  assign rd_word   = read_phase ? mem[cur_addr] : '0;
  assign DATA_OE_N = OUTPUT_DRIVE_N | !read_phase;
  assign LOW_POWER = sleep_sync | (phase == sram_port_pkg::PHASE_IDLE);

  property p_write_floats;
    write_pending || OUTPUT_DRIVE_N |-> DATA_OE_N;
  endproperty
  a_write_floats: assert property (p_write_floats)
    else $error("Data driven during write phase or with drive off");

  property p_read_drives;
    read_phase && !OUTPUT_DRIVE_N |-> !DATA_OE_N;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("Read data not driven while enabled");

  property p_low_power;
    sleep_sync && !stall
      |=> phase == sram_port_pkg::PHASE_IDLE && LOW_POWER;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("Sleep did not hold the low-power state");

endmodule

// [sram_master.sv]
`timescale 1ns/1ps
module sram_master (
  // Clock
  input  wire logic        clk,
  // Command lines
  output logic      [18:0] a,
  output logic             gate_n,
  output logic      [2:0]  cs,
  output logic             we_n,
  output logic      [3:0]  byte_sel_n,
  output logic             advance,
  // Data lines, parity on top
  output logic      [35:0] dq,
  input  wire logic [35:0] q,
  input  wire logic        q_oe_n
);
  logic        pend = 1'b0;
  logic        wr = 1'b0;
  logic [35:0] wdp = 36'h000000000;
  initial begin
    a = 19'h00000;
    gate_n = 1'b0;
    cs = 3'h0;
    we_n = 1'b1;
    byte_sel_n = 4'hF;
    advance = 1'b0;
    dq = 36'h000000000;
  end
  // Op 0 read, 1 write, 2 advance, 3 stall
  task automatic beat(input int op, input logic [2:0] sel,
                      input logic [18:0] adr, input logic [3:0] lane_n,
                      input logic [35:0] wd, output logic [35:0] rd,
                      output logic rd_oe_n);
    @(negedge clk);
    rd = q;
    rd_oe_n = q_oe_n;
    // Released bus shows inverted last value, or holds it on a stall
    if (pend)
      dq = wdp;
    else if (op != 3)
      dq = ~dq;
    gate_n = (op == 3);
    if (op != 3) begin
      cs = sel;
      a = adr;
      advance = (op == 2);
      we_n = (op != 1);
      byte_sel_n = lane_n;
      if (op != 2)
        wr = (op == 1) && (sel == 3'h2);
      pend = wr;
      wdp = wd;
    end
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ode_n = 1'b0;
  logic        sleep = 1'b0;
  logic        ilv = 1'b0;
  logic [35:0] rd;
  logic        roe;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  wire logic [18:0] a;
  wire logic [2:0]  cs;
  wire logic [3:0]  byte_sel_n;
  wire logic [35:0] dq;
  wire logic [35:0] q;
  wire logic        gate_n;
  wire logic        we_n;
  wire logic        advance;
  wire logic        oe_n;
  wire logic        lp;

  sram_port u_dut (
    .CLK(clk), .RST(rst), .ADDRESS(a), .CLOCK_GATE_N(gate_n),
    .CHIP_SELECT_FIRST_N(cs[2]), .CHIP_SELECT_SECOND(cs[1]),
    .CHIP_SELECT_THIRD_N(cs[0]), .WRITE_N(we_n),
    .BYTE_LANE_WRITE_SEL_N(byte_sel_n), .ADVANCE_OR_LOAD(advance),
    .OUTPUT_DRIVE_N(ode_n), .SLEEP_REQUEST(sleep),
    .BURST_INTERLEAVED(ilv), .DATA_IN(dq[31:0]),
    .DATA_OUT(q[31:0]), .PARITY_LANE_IN(dq[35:32]),
    .PARITY_LANE_OUT(q[35:32]), .DATA_OE_N(oe_n), .LOW_POWER(lp));

  sram_master u_m (
    .clk(clk), .a(a), .gate_n(gate_n), .cs(cs), .we_n(we_n),
    .byte_sel_n(byte_sel_n), .advance(advance), .dq(dq), .q(q),
    .q_oe_n(oe_n));

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [35:0] dv(input logic [18:0] ad);
    dv = {ad[3:0], 13'h0000, ad};
  endfunction

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic go(input int op, input logic [18:0] ad);
    u_m.beat(op, 3'h2, ad, 4'h0, dv(ad), rd, roe);
  endtask

  task automatic nop();
    u_m.beat(0, 3'h0, 19'h00000, 4'hF, 36'h0, rd, roe);
  endtask

  // Mode 0 separate loads, 1 linear burst, 2 interleaved burst
  task automatic rd4(input logic [18:0] s, input int mode);
    logic [18:0] e;
    for (int n = 0; n < 5; n++) begin
      if (n == 4)
        nop();
      else
        go((mode > 0 && n > 0) ? 2 : 0, s + (mode ? 19'h0 : 19'(n)));
      e = (mode == 2) ? s ^ 19'(n - 1) : s + 19'(n - 1);
      if (mode == 1)
        e[18:2] = s[18:2];
      if (n > 0)
        chk(rd, dv(e));
    end
  endtask

  task automatic t_lanes();
    u_m.beat(1, 3'h2, 19'h00010, 4'h0, 36'h9A5A5A5A5, rd, roe);
    u_m.beat(1, 3'h2, 19'h00010, 4'hA, 36'h6C3C3C3C3, rd, roe);
    nop();
    chk(roe, 1'b1);
    repeat (3) nop();
    go(0, 19'h00010);
    nop();
    chk(rd, 36'hCA5C3A5C3);
  endtask

  task automatic t_mix();
    for (int i = 0; i < 4; i++)
      go(1, 19'(20 + i));
    repeat (3) nop();
    for (int i = 0; i < 4; i++) begin
      go(1, 19'(24 + i));
      if (i > 0)
        chk(rd, dv(19'(19 + i)));
      go(0, 19'(20 + i));
      chk(roe, 1'b1);
    end
    nop();
    chk(rd, dv(19'h00017));
    repeat (3) nop();
    rd4(19'h00018, 0);
  endtask

  task automatic t_stall_async();
    go(0, 19'h00014);
    repeat (3) begin
      go(3, 19'h00000);
      chk(rd, dv(19'h00014));
    end
    ode_n = 1'b1;
    #5;
    chk(oe_n, 1'b1);
    go(3, 19'h00000);
    ode_n = 1'b0;
    #5;
    chk({oe_n, q}, {1'b0, dv(19'h00014)});
    nop();
  endtask

  task automatic t_cs();
    for (int s = 0; s < 8; s++) begin
      u_m.beat(0, 3'(s), 19'h00014, 4'hF, 36'h0, rd, roe);
      nop();
      chk({roe, lp}, {2{s != 2}});
    end
  endtask

  task automatic t_burst();
    for (int n = 0; n < 4; n++)
      go(n ? 2 : 1, 19'(64 + n));
    repeat (3) nop();
    rd4(19'h00041, 1);
    ilv = 1'b1;
    repeat (3) nop();
    rd4(19'h00042, 2);
  endtask

  task automatic t_sleep();
    for (int i = 0; i < 4; i++)
      go(1, 19'(80 + i));
    nop();
    sleep = 1'b1;
    repeat (3) nop();
    go(0, 19'h00014);
    nop();
    chk({roe, lp}, 2'h3);
    sleep = 1'b0;
    repeat (4) nop();
    rd4(19'h00050, 0);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk({oe_n, lp, q}, {2'h3, 36'h0});
    t_lanes();
    t_mix();
    t_stall_async();
    t_cs();
    t_burst();
    t_sleep();
    finish_test();
  end
endmodule
